/* File: rtl/qdac_device.sv */
// Device end: serial input port and register file of the quad DAC.
`timescale 1ns/1ps
// Notes on behaviour
// - Words are 24 bits, MSB first.
// - Decode rw, register, channel, data fields.
// - Frame starts on sync fall; shift while low.
// - Host gives exactly 24 falling edges.
// - Short frame is discarded.
// - Long frame is discarded.
// - Valid word commits on sync rise.
// - One sync low period per transfer.
// - Continuous clock needs exact sync window.
// - Load low with sync high updates all.
// - Reset zeroes all DAC registers.
// - Midscale code depends on coding.
// - Negative full scale depends on coding.
// - Major carry is 7fff to 8000.
// - Output shifts on rising serial clock.
// - Read word returns data next frame.
// - Load low while shifting updates on commit.
// - Clear sets zero or midscale code.
module qdac_device
    import qdac_pkg::*;
#(
    parameter int NCH = CH_NUM
) (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    // Link
    qdac_link_if.dev                  link,
    // Configuration pins
    input  wire logic                 coding_select_i,
    input  wire logic                 clear_mid_i,
    // DAC codes and status
    output logic [NCH*DATA_BITS-1:0]  dac_code_o,
    output logic                      outputs_clamped_o,
    output logic                      word_valid_o,
    output logic                      word_invalid_o,
    output logic                      carry_step_o
);
    logic [2:0] fs_sync_ff, ck_sync_ff, di_sync_ff, ld_sync_ff, cl_sync_ff;
    logic [WORD_BITS-1:0] shift_ff;
    logic [5:0]           cnt_ff;
    logic [DATA_BITS-1:0] in_reg_ff  [NCH];
    logic [DATA_BITS-1:0] dac_reg_ff [NCH];
    logic [WORD_BITS-1:0] rd_word_ff;
    logic                 sdo_ff;
    logic                 clamp_ff, valid_ff, invalid_ff, carry_ff;
    logic [NCH*DATA_BITS-1:0] code_ff;

    // Third stage only holds history for edges; levels read stage 2, edges stages 2..3.
    wire fs_n     = fs_sync_ff[1];
    wire fs_fall  = fs_sync_ff[2] & ~fs_sync_ff[1];
    wire fs_rise  = ~fs_sync_ff[2] & fs_sync_ff[1];
    wire ck_fall  = ck_sync_ff[2] & ~ck_sync_ff[1];
    wire ck_rise  = ~ck_sync_ff[2] & ck_sync_ff[1];
    wire sdi      = di_sync_ff[1];
    wire ld_n     = ld_sync_ff[1];
    wire ld_fall  = ld_sync_ff[2] & ~ld_sync_ff[1];
    wire clr_n    = cl_sync_ff[1];

    wire       w_rw   = shift_ff[RW_POS];
    wire [2:0] w_reg  = shift_ff[REG_HI:REG_LO];
    wire [2:0] w_ch   = shift_ff[CH_HI:CH_LO];
    wire [DATA_BITS-1:0] w_data = shift_ff[DATA_BITS-1:0];
    wire word_ok  = (cnt_ff == 6'(BIT_COUNT));
    wire commit   = fs_rise & word_ok & ~w_rw;
    wire rd_req   = fs_rise & word_ok & w_rw;
    wire clr_code = (w_reg == REG_CTRL) && (w_ch == CTRL_CLR);
    wire ld_cmd   = (w_reg == REG_CTRL) && (w_ch == CTRL_LOAD);
    wire [DATA_BITS-1:0] clr_val =
        clear_mid_i ? qdac_mid_code(coding_select_i)
                    : qdac_negfs_code(coding_select_i);
    wire upd_all  = (fs_n & ld_fall) | (commit & ld_cmd);
    wire [DATA_BITS-1:0] sel_rd =
        (w_reg == REG_DAC && w_ch < 3'(NCH)) ? dac_reg_ff[w_ch[1:0]]
                                              : in_reg_ff[w_ch[1:0]];

    always_ff @(posedge ref_clk_i) begin
        fs_sync_ff <= {fs_sync_ff[1:0], link.frame_sync_n};
        ck_sync_ff <= {ck_sync_ff[1:0], link.serial_clk};
        di_sync_ff <= {di_sync_ff[1:0], link.serial_data_in};
        ld_sync_ff <= {ld_sync_ff[1:0], link.load_outputs_n};
        cl_sync_ff <= {cl_sync_ff[1:0], link.clear_outputs_n};
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            shift_ff <= '0;
            cnt_ff   <= '0;
            sdo_ff   <= 1'b0;
        end else if (fs_fall) begin
            shift_ff <= rd_word_ff;
            cnt_ff   <= '0;
            sdo_ff   <= rd_word_ff[WORD_BITS-1];
        end else if (!fs_n && ck_fall) begin
            shift_ff <= {shift_ff[WORD_BITS-2:0], sdi};
            if (cnt_ff != 6'h3f) cnt_ff <= cnt_ff + 6'h01;
        end else if (!fs_n && ck_rise && cnt_ff != 6'h00) begin
            sdo_ff   <= shift_ff[WORD_BITS-1];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_word_ff <= '0;
        end else if (rd_req) begin
            rd_word_ff <= {shift_ff[WORD_BITS-1:DATA_BITS], sel_rd};
        end else if (commit) begin
            rd_word_ff <= '0;
        end
    end

    // Readback data is loaded into the shifter at the start of the next
    // frame, so the first bit leaves before any clock edge.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NCH; i++) begin
                in_reg_ff[i]  <= CODE_ZERO;
                dac_reg_ff[i] <= CODE_ZERO;
            end
            clamp_ff <= 1'b1;
        end else if (!clr_n || (commit && clr_code)) begin
            for (int i = 0; i < NCH; i++) dac_reg_ff[i] <= clr_val;
        end else begin
            if (commit && w_reg == REG_DAC && w_ch < 3'(NCH)) begin
                in_reg_ff[w_ch[1:0]] <= w_data;
                if (!ld_n) begin
                    dac_reg_ff[w_ch[1:0]] <= w_data;
                    clamp_ff <= 1'b0;
                end
            end
            if (upd_all) begin
                for (int i = 0; i < NCH; i++) dac_reg_ff[i] <= in_reg_ff[i];
                clamp_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            valid_ff   <= 1'b0;
            invalid_ff <= 1'b0;
            carry_ff   <= 1'b0;
            code_ff    <= '0;
        end else begin
            valid_ff   <= fs_rise & word_ok;
            invalid_ff <= fs_rise & ~word_ok;
            carry_ff   <= (code_ff[DATA_BITS-1:0] == CODE_CARRY_LO) &&
                          (dac_reg_ff[0] == CODE_CARRY_HI);
            for (int i = 0; i < NCH; i++)
                code_ff[i*DATA_BITS +: DATA_BITS] <= dac_reg_ff[i];
        end
    end

    assign link.serial_data_out = sdo_ff;
    assign dac_code_o        = code_ff;
    assign outputs_clamped_o = clamp_ff;
    assign word_valid_o      = valid_ff;
    assign word_invalid_o    = invalid_ff;
    assign carry_step_o      = carry_ff;
endmodule : qdac_device

/* File: rtl/qdac_host.sv */
// Host end: register-driven serial master for the quad DAC port.
`timescale 1ns/1ps
module qdac_host
    import qdac_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    // Link
    qdac_link_if.host        link
);
    typedef enum logic [2:0] {
        QH_IDLE = 3'b001,
        QH_SHIFT = 3'b010,
        QH_END = 3'b100
    } qh_state_e;
    qh_state_e st_ff;
    // Two-entry command buffer decouples software from the link.
    logic [WORD_BITS:0] buf_ff [2];
    logic               wp_ff, rp_ff;
    logic [1:0]         cnt_ff;
    logic [WORD_BITS-1:0] tx_ff, rx_ff, last_rx_ff;
    logic [7:0]  div_ff;
    logic [4:0]  bits_ff;
    logic        fs_ff, ck_ff, sdi_ff, ld_ff, cl_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  sdo_sync_ff;
    wire in_ready  = (cnt_ff != 2'd2);
    wire in_valid  = wr_i && addr_i == HOST_CMD_ADDR;
    wire out_valid = (cnt_ff != 2'd0);
    wire out_ready = (st_ff == QH_IDLE);
    wire push      = in_valid & in_ready;
    wire pop       = out_valid & out_ready;
    wire tick      = (div_ff == DIV_HALF);
    always_ff @(posedge ref_clk_i) begin
        sdo_sync_ff <= {sdo_sync_ff[0], link.serial_data_out};
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            cnt_ff <= 2'd0;
        end else begin
            if (push) buf_ff[wp_ff] <= wdata_i[WORD_BITS:0];
            if (push) wp_ff <= ~wp_ff;
            if (pop) rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_ff <= QH_IDLE;
            div_ff <= CNT_RESET;
            fs_ff <= 1'b1;
            ck_ff <= 1'b0;
            sdi_ff <= 1'b0;
            ld_ff <= 1'b1;
            cl_ff <= 1'b1;
            bits_ff <= 5'd0;
            tx_ff <= '0;
            rx_ff <= '0;
            last_rx_ff <= '0;
        end else begin
            div_ff <= tick ? CNT_RESET : div_ff + 8'h01;
            if (wr_i && addr_i == HOST_STAT_ADDR) begin
                ld_ff <= wdata_i[0];
                cl_ff <= wdata_i[1];
            end
            case (st_ff)
                QH_IDLE: begin
                    if (pop) begin
                        tx_ff <= buf_ff[rp_ff][WORD_BITS-1:0];
                        sdi_ff <= buf_ff[rp_ff][WORD_BITS-1];
                        fs_ff <= 1'b0;
                        bits_ff <= 5'd0;
                        div_ff <= CNT_RESET;
                        st_ff <= QH_SHIFT;
                    end
                end
                QH_SHIFT: begin
                    if (tick) begin
                        ck_ff <= ~ck_ff;
                        if (!ck_ff) begin
                            sdi_ff <= tx_ff[WORD_BITS-1];
                        end else begin
                            rx_ff <= {rx_ff[WORD_BITS-2:0], sdo_sync_ff[1]};
                            tx_ff <= {tx_ff[WORD_BITS-2:0], 1'b0};
                            bits_ff <= bits_ff + 5'd1;
                            if (bits_ff == BIT_COUNT - 5'd1) st_ff <= QH_END;
                        end
                    end
                end
                QH_END: begin
                    if (tick) begin
                        fs_ff <= 1'b1;
                        last_rx_ff <= rx_ff;
                        st_ff <= QH_IDLE;
                    end
                end
                default: st_ff <= QH_IDLE;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) rdata_ff <= '0;
        else if (rd_i && addr_i == HOST_STAT_ADDR)
            rdata_ff <= {26'h0, cnt_ff, st_ff != QH_IDLE, in_ready, cl_ff,
                         ld_ff};
        else if (rd_i && addr_i == HOST_RDATA_ADDR)
            rdata_ff <= {8'h00, last_rx_ff};
        else rdata_ff <= '0;
    end
    assign rdata_o = rdata_ff;
    assign link.frame_sync_n = fs_ff;
    assign link.serial_clk = ck_ff;
    assign link.serial_data_in = sdi_ff;
    assign link.load_outputs_n = ld_ff;
    assign link.clear_outputs_n = cl_ff;
endmodule : qdac_host

/* File: rtl/qdac_link_if.sv */
// Interface joining the serial host and the quad DAC port.
`timescale 1ns/1ps
interface qdac_link_if;
    logic frame_sync_n;
    logic serial_clk;
    logic serial_data_in;
    logic serial_data_out;
    logic load_outputs_n;
    logic clear_outputs_n;
    modport host (
        output frame_sync_n, serial_clk, serial_data_in,
        output load_outputs_n, clear_outputs_n,
        input  serial_data_out
    );
    modport dev (
        input  frame_sync_n, serial_clk, serial_data_in,
        input  load_outputs_n, clear_outputs_n,
        output serial_data_out
    );
endinterface : qdac_link_if

/* File: rtl/qdac_pkg.sv */
// Package of shared constants for the quad DAC serial port.
package qdac_pkg;
    localparam int WORD_BITS = 24;
    localparam int DATA_BITS = 16;
    localparam int CH_NUM    = 4;
    localparam int RW_POS    = 23;
    localparam int RSV_POS   = 22;
    localparam int REG_HI    = 21;
    localparam int REG_LO    = 19;
    localparam int CH_HI     = 18;
    localparam int CH_LO     = 16;
    localparam logic [2:0] REG_DAC  = 3'h0;
    localparam logic [2:0] REG_CTRL = 3'h3;
    localparam logic [2:0] CTRL_NOP = 3'h0;
    localparam logic [2:0] CTRL_CLR = 3'h4;
    localparam logic [2:0] CTRL_LOAD = 3'h5;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID  = 16'h8000;
    localparam logic [15:0] CODE_CARRY_LO = 16'h7fff;
    localparam logic [15:0] CODE_CARRY_HI = 16'h8000;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] DIV_HALF  = 8'h14;
    localparam logic [4:0] BIT_COUNT = 5'd24;
    localparam logic [7:0] HOST_CMD_ADDR = 8'h00;
    localparam logic [7:0] HOST_STAT_ADDR = 8'h04;
    localparam logic [7:0] HOST_RDATA_ADDR = 8'h08;
    // Negative full scale and bipolar zero per coding mode.
    function automatic logic [15:0] qdac_mid_code(input logic twos);
        qdac_mid_code = twos ? CODE_ZERO : CODE_MID;
    endfunction : qdac_mid_code
    function automatic logic [15:0] qdac_negfs_code(input logic twos);
        qdac_negfs_code = twos ? CODE_MID : CODE_ZERO;
    endfunction : qdac_negfs_code
endpackage : qdac_pkg

/* File: verification/qdac_link_assertions.sv */
// Checker of the serial link between the host end and the device end.
`timescale 1ns/1ps
module qdac_link_assertions (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Link signals
    input wire logic frame_sync_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic serial_data_out
);
    logic       sclk_d_ff;
    logic [5:0] fall_cnt_ff;
    logic [10:0] low_cnt_ff;
    wire        sclk_fell = sclk_d_ff & ~serial_clk;
    always_ff @(posedge ref_clk_i) begin
        sclk_d_ff <= serial_clk;
    end
    // The count restarts while idle, so an edge outside a frame never leaks.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || frame_sync_n) begin
            fall_cnt_ff <= 6'h00;
        end else begin
            fall_cnt_ff <= fall_cnt_ff + {5'h00, sclk_fell};
        end
    end
    // Frame length is counted here, as a delay range this long is too slow.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || frame_sync_n) begin
            low_cnt_ff <= 11'h000;
        end else if (low_cnt_ff != 11'h7ff) begin
            low_cnt_ff <= low_cnt_ff + 11'h001;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    idle_clk_low_a: assert property (
        frame_sync_n |-> !serial_clk) else $error("clock outside frame");
    frame_lead_a: assert property (
        $fell(frame_sync_n) |-> !serial_clk [*8]) else $error("no lead in");
    frame_length_a: assert property (
        $rose(frame_sync_n) |-> low_cnt_ff >= 11'd1000 &&
        low_cnt_ff <= 11'd1060)
        else $error("frame length wrong");
    edge_count_a: assert property (
        $rose(frame_sync_n) |-> fall_cnt_ff == 6'd24)
        else $error("frame edge count wrong");
    data_hold_a: assert property (
        $rose(serial_clk) |=> $stable(serial_data_in) [*8])
        else $error("data moved while clock high");
    half_period_a: assert property (
        $rose(serial_clk) |-> serial_clk [*8] ##[12:14] $fell(serial_clk))
        else $error("clock half period wrong");
    sdo_stable_a: assert property (
        $fell(serial_clk) |-> $stable(serial_data_out))
        else $error("output moved at falling edge");
    tail_gap_a: assert property (
        sclk_fell && fall_cnt_ff == 6'd23 |-> !frame_sync_n [*8])
        else $error("frame closed too early");
endmodule : qdac_link_assertions

/* File: verification/quad_dac_serial_input_port_tb.sv */
// Testbench joining the host end and the device end of the DAC link.
`timescale 1ns/1ps
module quad_dac_serial_input_port_tb;
    import qdac_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [7:0]  addr      = 8'h00;
    logic [31:0] wdata     = 32'h0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        coding    = 1'b0;
    logic        clr_mid   = 1'b0;
    logic        saw_carry = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [63:0] dac1;
    logic [63:0] dac2;
    logic        clamp1, v1, v2, inv2, carry1;
    int          n_v1 = 0, n_v2 = 0, n_inv2 = 0, checks = 0, n_fail = 0;
    qdac_link_if lnk();
    qdac_link_if lnk2();
    qdac_host i_qdac_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .link(lnk));
    qdac_device i_qdac_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .link(lnk), .coding_select_i(coding), .clear_mid_i(clr_mid),
        .dac_code_o(dac1), .outputs_clamped_o(clamp1), .word_valid_o(v1),
        .word_invalid_o(), .carry_step_o(carry1));
    // Second device faces a driver that breaks the framing on purpose.
    qdac_device i_qdac_device_2 (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .link(lnk2), .coding_select_i(coding), .clear_mid_i(clr_mid),
        .dac_code_o(dac2), .outputs_clamped_o(), .word_valid_o(v2),
        .word_invalid_o(inv2), .carry_step_o());
    qdac_link_assertions i_qdac_link_assertions (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .frame_sync_n(lnk.frame_sync_n),
        .serial_clk(lnk.serial_clk), .serial_data_in(lnk.serial_data_in),
        .serial_data_out(lnk.serial_data_out));
    always #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (v1 === 1'b1) n_v1 <= n_v1 + 1;
        if (v2 === 1'b1) n_v2 <= n_v2 + 1;
        if (inv2 === 1'b1) n_inv2 <= n_inv2 + 1;
        if (carry1 === 1'b1) saw_carry <= 1'b1;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string msg);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        @(posedge ref_clk_i);
        v = rdata;
    endtask : bus_rd
    // Waits for a given number of accepted words, each frame is ~1030 cycles.
    task automatic wait_v1(input int n);
        for (int k = 0; k < 1200 * n && n_v1 < n; k++) @(posedge ref_clk_i);
        chk(64'(n_v1), 64'(n), "word count");
    endtask : wait_v1
    task automatic cmd(input logic [23:0] w);
        bus_wr(HOST_CMD_ADDR, {8'h00, w});
        wait_v1(n_v1 + 1);
    endtask : cmd
    // Bit-banged frame with a 160 ns serial clock and a chosen edge count.
    task automatic raw(input logic [24:0] w, input int n);
        lnk2.frame_sync_n <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            lnk2.serial_data_in <= w[i];
            repeat (10) @(posedge ref_clk_i);
            lnk2.serial_clk <= 1'b1;
            repeat (20) @(posedge ref_clk_i);
            lnk2.serial_clk <= 1'b0;
            repeat (10) @(posedge ref_clk_i);
        end
        repeat (10) @(posedge ref_clk_i);
        lnk2.frame_sync_n <= 1'b1;
        lnk2.serial_data_in <= ~lnk2.serial_data_in;
        repeat (30) @(posedge ref_clk_i);
    endtask : raw
    task automatic finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        n_fail++;
        finish_test();
    end
    initial begin
        lnk2.frame_sync_n <= 1'b1;
        lnk2.serial_clk <= 1'b0;
        lnk2.serial_data_in <= 1'b0;
        lnk2.load_outputs_n <= 1'b0;
        lnk2.clear_outputs_n <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        chk(dac1, 64'h0, "reset codes");
        chk(64'(clamp1), 64'h1, "reset clamp");
        bus_rd(HOST_STAT_ADDR, d);
        chk(64'(d[3:0]), 64'h7, "idle status");
        bus_wr(HOST_STAT_ADDR, 32'h2);
        cmd(24'h011234);
        chk(64'(dac1[31:16]), 64'h1234, "single update");
        chk(64'(clamp1), 64'h0, "clamp released");
        bus_wr(HOST_STAT_ADDR, 32'h3);
        cmd(24'h02abcd);
        chk(64'(dac1[47:32]), 64'h0, "held until load");
        bus_wr(HOST_STAT_ADDR, 32'h2);
        repeat (10) @(posedge ref_clk_i);
        chk(64'(dac1[47:32]), 64'habcd, "load all");
        cmd(24'h810000);
        cmd(24'h180000);
        bus_rd(HOST_RDATA_ADDR, d);
        chk(64'(d[23:0]), 64'h811234, "readback");
        cmd(24'h007fff);
        repeat (4) @(posedge ref_clk_i);
        chk(64'(saw_carry), 64'h0, "no carry");
        cmd(24'h008000);
        repeat (4) @(posedge ref_clk_i);
        chk(64'(saw_carry), 64'h1, "major carry");
        // A full buffer refuses the fourth word, so only three frames follow.
        for (int k = 0; k < 4; k++) bus_wr(HOST_CMD_ADDR, 32'h180000);
        bus_rd(HOST_STAT_ADDR, d);
        chk(64'(d[2]), 64'h0, "buffer full");
        wait_v1(n_v1 + 3);
        repeat (1200) @(posedge ref_clk_i);
        chk(64'(n_v1), 64'd9, "refused word");
        // Midscale is 8000 or 0000, zero scale the reverse, by coding.
        for (int m = 0; m < 4; m++) begin
            coding <= m[0];
            clr_mid <= m[1];
            bus_wr(HOST_STAT_ADDR, 32'h1);
            repeat (10) @(posedge ref_clk_i);
            chk(dac1, {4{(m[0] ^ m[1]) ? 16'h8000 : 16'h0000}}, "clear");
            bus_wr(HOST_STAT_ADDR, 32'h3);
        end
        raw({1'b0, 24'h02aaaa}, 24);
        chk(64'(dac2[47:32]), 64'haaaa, "valid frame");
        for (int n = 23; n <= 25; n += 2) raw(25'h0025555, n);
        chk(64'(n_inv2), 64'h2, "bad frames");
        chk(64'(dac2[47:32]), 64'haaaa, "bad frame kept");
        finish_test();
    end
endmodule : quad_dac_serial_input_port_tb
